// ### paf_pkg.sv
// Shared types, constants and helpers for the arithmetic and flag unit.
// Assumes one clock domain driven by the instruction sequencer.
package paf_pkg;

    localparam int PAF_WORD_W = 16;
    localparam int PAF_DWORD_W = 32;

    // Divider runs one quotient bit per clock.
    localparam logic [5:0] PAF_DIV_STEPS = 6'h20;
    localparam logic [5:0] PAF_DIV_CNT_RST = 6'h00;
    localparam logic [3:0] PAF_MASK_NONE = 4'h0;
    localparam logic [3:0] PAF_MASK_ONE = 4'h1;
    localparam logic [3:0] PAF_MASK_TWO = 4'h3;
    localparam logic [3:0] PAF_MASK_FOUR = 4'hf;
    localparam logic [3:0] PAF_BCD_MAX_DIGIT = 4'h9;

    // Operation codes presented by the sequencer.
    typedef enum logic [3:0] {
        OP_ADD_SIGNED_SINGLE = 4'h0,
        OP_ADD_SIGNED_DOUBLE = 4'h1,
        OP_ADD_SIGNED_CARRY_SINGLE = 4'h2,
        OP_ADD_SIGNED_CARRY_DOUBLE = 4'h3,
        OP_ADD_DECIMAL_SINGLE = 4'h4,
        OP_ADD_DECIMAL_DOUBLE = 4'h5,
        OP_ADD_DECIMAL_CARRY_SINGLE = 4'h6,
        OP_ADD_DECIMAL_CARRY_DOUBLE = 4'h7,
        OP_SUB_BINARY_SINGLE = 4'h8,
        OP_SUB_BINARY_DOUBLE = 4'h9,
        OP_SUB_BINARY_CARRY_SINGLE = 4'ha,
        OP_DIVIDE_BINARY_DOUBLE = 4'hb
    } paf_op_t;

    // Unit state: idle, or stepping the divider.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DIV_RUN = 2'b01
    } paf_state_t;

    // One request; opnd_a is augend, minuend or dividend, opnd_b the other.
    typedef struct packed {
        paf_op_t op;
        logic exec_cond;
        logic ptr_bcd_err;
        logic [31:0] opnd_a;
        logic [31:0] opnd_b;
    } paf_req_t;

    // Up to four result words.
    typedef struct packed {
        logic [15:0] word3;
        logic [15:0] word2;
        logic [15:0] word1;
        logic [15:0] word0;
    } paf_result_t;

    // Condition flags.
    typedef struct packed {
        logic error_flag;
        logic carry_flag;
        logic equal_zero_flag;
        logic negative_flag;
        logic overflow_flag;
        logic underflow_flag;
    } paf_flags_t;

    localparam paf_flags_t PAF_FLAGS_RST = '0;
    localparam paf_result_t PAF_RESULT_RST = '0;

    // True when the low nibbles (four or eight of them) are all decimal.
    function automatic logic paf_bcd_ok(input logic [31:0] v,
                                        input logic dbl);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            if ((i < 4 || dbl) && v[4*i +: 4] > PAF_BCD_MAX_DIGIT)
            begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

endpackage

// ### paf_bcd_adder.sv
// Eight-digit decimal adder with carry out after digit four and eight.
// Assumes operands hold valid decimal digits; the caller checks that.
module paf_bcd_adder
(
    // Operands and incoming carry.
    input wire logic [31:0] a,
    input wire logic [31:0] b,
    input wire logic cin,
    // Sum and the two carry taps.
    output logic [31:0] sum,
    output logic carry_lo,
    output logic carry_hi
);
    import paf_pkg::*;

    // Ripple through the digits, correcting each one above nine.
    always_comb
    begin
        logic c;
        logic [4:0] s5;
        c = cin;
        s5 = 5'h00;
        sum = 32'h0000_0000;
        carry_lo = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            s5 = {1'b0, a[4*i +: 4]} + {1'b0, b[4*i +: 4]} + {4'h0, c};
            if (s5 > {1'b0, PAF_BCD_MAX_DIGIT})
            begin
                sum[4*i +: 4] = 4'(s5 - 5'h0a);
                c = 1'b1;
            end
            else
            begin
                sum[4*i +: 4] = s5[3:0];
                c = 1'b0;
            end
            if (i == 3)
            begin
                carry_lo = c;
            end
        end
        carry_hi = c;
    end

endmodule // paf_bcd_adder

// ### paf_arith_unit.sv
// Arithmetic and flag unit: binary and decimal add, binary subtract and
// a double-word divide. Assumes the sequencer holds off while busy is high
// and presents one request per cycle on req_valid.
module paf_arith_unit
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Request from the sequencer.
    input wire logic req_valid,
    input wire paf_pkg::paf_req_t req,
    // Completion and result.
    output logic busy,
    output logic done,
    output logic [3:0] wr_mask,
    output paf_pkg::paf_result_t result,
    // Condition flags.
    output paf_pkg::paf_flags_t flags
);
    import paf_pkg::*;

    paf_state_t state_ff, nxt_state;
    logic busy_ff, nxt_busy;
    logic done_ff, nxt_done;
    logic [3:0] wr_mask_ff, nxt_wr_mask;
    paf_result_t result_ff, nxt_result;
    paf_flags_t flags_ff, nxt_flags;
    logic [31:0] dvd_ff, nxt_dvd;
    logic [31:0] rem_ff, nxt_rem;
    logic [31:0] dsr_ff, nxt_dsr;
    logic [5:0] cnt_ff, nxt_cnt;

    logic [31:0] bcd_sum;
    logic bcd_c_lo;
    logic bcd_c_hi;
    logic cin;
    logic take;

    assign take = req_valid && state_ff == ST_IDLE;
    assign cin = flags_ff.carry_flag;

    // Decimal digit chain shared by all four decimal add forms.
    paf_bcd_adder u_bcd
    (
        .a(req.opnd_a),
        .b(req.opnd_b),
        .cin(cin && (req.op == OP_ADD_DECIMAL_CARRY_SINGLE ||
                     req.op == OP_ADD_DECIMAL_CARRY_DOUBLE)),
        .sum(bcd_sum),
        .carry_lo(bcd_c_lo),
        .carry_hi(bcd_c_hi)
    );

    // Next values for the request, result, flags and divider.
    always_comb
    begin
        logic [16:0] s17;
        logic [32:0] s33;
        logic [32:0] trial;
        logic [31:0] shifted;
        logic sa;
        logic sb;
        logic sr;
        logic dbl;
        s17 = 17'h0_0000;
        s33 = 33'h0_0000_0000;
        trial = 33'h0_0000_0000;
        shifted = 32'h0000_0000;
        sa = 1'b0;
        sb = 1'b0;
        sr = 1'b0;
        dbl = 1'b0;
        nxt_state = state_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        nxt_wr_mask = PAF_MASK_NONE;
        nxt_result = result_ff;
        nxt_flags = flags_ff;
        nxt_dvd = dvd_ff;
        nxt_rem = rem_ff;
        nxt_dsr = dsr_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (take && req.exec_cond)
                begin
                    nxt_done = 1'b1;
                    nxt_flags.error_flag = 1'b0;
                    if (req.ptr_bcd_err)
                    begin
                        nxt_flags.error_flag = 1'b1;
                    end
                    else
                    begin
                        case (req.op)
                            OP_ADD_SIGNED_SINGLE,
                            OP_ADD_SIGNED_CARRY_SINGLE,
                            OP_SUB_BINARY_SINGLE,
                            OP_SUB_BINARY_CARRY_SINGLE:
                            begin
                                if (req.op == OP_ADD_SIGNED_SINGLE ||
                                    req.op == OP_ADD_SIGNED_CARRY_SINGLE)
                                begin
                                    s17 = {1'b0, req.opnd_a[15:0]} +
                                          {1'b0, req.opnd_b[15:0]} +
                                          {16'h0000,
                                           cin && req.op ==
                                           OP_ADD_SIGNED_CARRY_SINGLE};
                                    sb = req.opnd_b[15];
                                end
                                else
                                begin
                                    s17 = {1'b0, req.opnd_a[15:0]} -
                                          {1'b0, req.opnd_b[15:0]} -
                                          {16'h0000,
                                           cin && req.op ==
                                           OP_SUB_BINARY_CARRY_SINGLE};
                                    sb = ~req.opnd_b[15];
                                end
                                sa = req.opnd_a[15];
                                sr = s17[15];
                                nxt_result.word0 = s17[15:0];
                                nxt_wr_mask = PAF_MASK_ONE;
                                nxt_flags.carry_flag = s17[16];
                                nxt_flags.equal_zero_flag =
                                    s17[15:0] == 16'h0000;
                                nxt_flags.negative_flag = sr;
                                nxt_flags.overflow_flag = !sa && !sb && sr;
                                nxt_flags.underflow_flag = sa && sb && !sr;
                            end
                            OP_ADD_SIGNED_DOUBLE,
                            OP_ADD_SIGNED_CARRY_DOUBLE,
                            OP_SUB_BINARY_DOUBLE:
                            begin
                                if (req.op != OP_SUB_BINARY_DOUBLE)
                                begin
                                    s33 = {1'b0, req.opnd_a} +
                                          {1'b0, req.opnd_b} +
                                          {32'h0000_0000,
                                           cin && req.op ==
                                           OP_ADD_SIGNED_CARRY_DOUBLE};
                                    sb = req.opnd_b[31];
                                end
                                else
                                begin
                                    s33 = {1'b0, req.opnd_a} -
                                          {1'b0, req.opnd_b};
                                    sb = ~req.opnd_b[31];
                                end
                                sa = req.opnd_a[31];
                                sr = s33[31];
                                nxt_result.word0 = s33[15:0];
                                nxt_result.word1 = s33[31:16];
                                nxt_wr_mask = PAF_MASK_TWO;
                                nxt_flags.carry_flag = s33[32];
                                nxt_flags.equal_zero_flag =
                                    s33[31:0] == 32'h0000_0000;
                                nxt_flags.negative_flag = sr;
                                nxt_flags.overflow_flag = !sa && !sb && sr;
                                nxt_flags.underflow_flag = sa && sb && !sr;
                            end
                            OP_ADD_DECIMAL_SINGLE,
                            OP_ADD_DECIMAL_CARRY_SINGLE,
                            OP_ADD_DECIMAL_DOUBLE,
                            OP_ADD_DECIMAL_CARRY_DOUBLE:
                            begin
                                dbl = req.op == OP_ADD_DECIMAL_DOUBLE ||
                                      req.op == OP_ADD_DECIMAL_CARRY_DOUBLE;
                                if (!paf_bcd_ok(req.opnd_a, dbl) ||
                                    !paf_bcd_ok(req.opnd_b, dbl))
                                begin
                                    nxt_flags.error_flag = 1'b1;
                                end
                                else if (dbl)
                                begin
                                    nxt_result.word0 = bcd_sum[15:0];
                                    nxt_result.word1 = bcd_sum[31:16];
                                    nxt_wr_mask = PAF_MASK_TWO;
                                    nxt_flags.carry_flag = bcd_c_hi;
                                    nxt_flags.equal_zero_flag =
                                        bcd_sum == 32'h0000_0000;
                                end
                                else
                                begin
                                    nxt_result.word0 = bcd_sum[15:0];
                                    nxt_wr_mask = PAF_MASK_ONE;
                                    nxt_flags.carry_flag = bcd_c_lo;
                                    nxt_flags.equal_zero_flag =
                                        bcd_sum[15:0] == 16'h0000;
                                end
                            end
                            OP_DIVIDE_BINARY_DOUBLE:
                            begin
                                if (req.opnd_b == 32'h0000_0000)
                                begin
                                    nxt_flags.error_flag = 1'b1;
                                end
                                else
                                begin
                                    nxt_dvd = req.opnd_a;
                                    nxt_dsr = req.opnd_b;
                                    nxt_flags.error_flag =
                                        flags_ff.error_flag;
                                    nxt_rem = 32'h0000_0000;
                                    nxt_cnt = PAF_DIV_CNT_RST;
                                    nxt_busy = 1'b1;
                                    nxt_done = 1'b0;
                                    nxt_state = ST_DIV_RUN;
                                end
                            end
                            default:
                            begin
                                nxt_flags.error_flag = 1'b1;
                            end
                        endcase
                    end
                end
            end
            ST_DIV_RUN:
            begin
                // One restoring step per clock, quotient into the low end.
                trial = {rem_ff, dvd_ff[31]} - {1'b0, dsr_ff};
                if (!trial[32])
                begin
                    shifted = trial[31:0];
                end
                else
                begin
                    shifted = {rem_ff[30:0], dvd_ff[31]};
                end
                nxt_rem = shifted;
                nxt_dvd = {dvd_ff[30:0], !trial[32]};
                nxt_cnt = cnt_ff + 6'h01;
                if (cnt_ff == PAF_DIV_STEPS - 6'h01)
                begin
                    nxt_result.word0 = nxt_dvd[15:0];
                    nxt_result.word1 = nxt_dvd[31:16];
                    nxt_result.word2 = shifted[15:0];
                    nxt_result.word3 = shifted[31:16];
                    nxt_wr_mask = PAF_MASK_FOUR;
                    nxt_flags.error_flag = 1'b0;
                    nxt_flags.negative_flag = nxt_dvd[31];
                    nxt_flags.equal_zero_flag =
                        nxt_dvd == 32'h0000_0000 &&
                        shifted == 32'h0000_0000;
                    nxt_done = 1'b1;
                    nxt_busy = 1'b0;
                    nxt_state = ST_IDLE;
                end
            end
            default:
            begin
                nxt_busy = 1'b0;
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Register every piece of state.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state_ff <= ST_IDLE;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            wr_mask_ff <= PAF_MASK_NONE;
            result_ff <= PAF_RESULT_RST;
            flags_ff <= PAF_FLAGS_RST;
            dvd_ff <= 32'h0000_0000;
            rem_ff <= 32'h0000_0000;
            dsr_ff <= 32'h0000_0000;
            cnt_ff <= PAF_DIV_CNT_RST;
        end
        else
        begin
            state_ff <= nxt_state;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            wr_mask_ff <= nxt_wr_mask;
            result_ff <= nxt_result;
            flags_ff <= nxt_flags;
            dvd_ff <= nxt_dvd;
            rem_ff <= nxt_rem;
            dsr_ff <= nxt_dsr;
            cnt_ff <= nxt_cnt;
        end
    end

    // Outputs straight from flip-flops.
    assign busy = busy_ff;
    assign done = done_ff;
    assign wr_mask = wr_mask_ff;
    assign result = result_ff;
    assign flags = flags_ff;

endmodule // paf_arith_unit

// ### paf_arith_unit_properties.sv
// Concurrent checks on the arithmetic and flag unit ports.
// Assumes one clock domain and the synchronous active-high reset.
module paf_arith_unit_chk
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Request side.
    input wire logic req_valid,
    input wire paf_pkg::paf_req_t req,
    // Completion side.
    input wire logic busy,
    input wire logic done,
    input wire logic [3:0] wr_mask,
    input wire paf_pkg::paf_result_t result,
    input wire paf_pkg::paf_flags_t flags
);
    import paf_pkg::*;
    logic take;
    logic skip;
    logic is_div;
    logic [16:0] sum17;
    logic borrow16;

    // Decode what the unit accepts at this edge, and the expected sums.
    assign take = req_valid && !busy && req.exec_cond;
    assign skip = req_valid && !busy && !req.exec_cond;
    assign is_div = req.op == OP_DIVIDE_BINARY_DOUBLE;
    assign sum17 = {1'b0, req.opnd_a[15:0]} + {1'b0, req.opnd_b[15:0]};
    assign borrow16 = req.opnd_a[15:0] < req.opnd_b[15:0];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_skip_no_done: assert property (skip |=> !done)
        else $error("Skipped request completed.");
    a_skip_flags_hold: assert property
        (skip |=> $stable(flags) && $stable(result))
        else $error("Skipped request changed state.");
    a_single_done: assert property (take && !is_div |=> done && !busy)
        else $error("Single-cycle operation did not complete.");
    a_div_timing: assert property
        (take && is_div && !req.ptr_bcd_err && req.opnd_b != 32'h0
         |=> busy ##32 (done && !busy && wr_mask == 4'hf))
        else $error("Divide did not finish on time.");
    a_div_zero_err: assert property
        (take && is_div && req.opnd_b == 32'h0
         |=> done && wr_mask == 4'h0 && flags.error_flag)
        else $error("Zero divisor not refused.");
    a_mask_quiet: assert property (!done |-> wr_mask == 4'h0)
        else $error("Write mask outside completion.");
    a_flags_only_done: assert property (!$stable(flags) |-> done)
        else $error("Flags moved without completion.");
    a_add_sum_carry: assert property
        (take && req.op == OP_ADD_SIGNED_SINGLE && !req.ptr_bcd_err
         |=> {flags.carry_flag, result.word0} == $past(sum17))
        else $error("Single add sum or carry wrong.");
    a_bcd_digit: assert property
        (take && req.op == OP_ADD_DECIMAL_SINGLE && req.opnd_a[3:0] > 4'h9
         |=> done && wr_mask == 4'h0 && flags.error_flag)
        else $error("Bad decimal digit not refused.");
    a_sub_borrow: assert property
        (take && req.op == OP_SUB_BINARY_SINGLE && !req.ptr_bcd_err
         |=> flags.carry_flag == $past(borrow16))
        else $error("Subtract borrow wrong.");
endmodule // paf_arith_unit_chk

bind paf_arith_unit paf_arith_unit_chk u_chk (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .req_valid(req_valid), .req(req), .busy(busy),
    .done(done), .wr_mask(wr_mask), .result(result), .flags(flags));

// ### tb_top.sv
// Self-checking bench for the arithmetic and flag unit.
// Assumes the checker is bound to the unit by its own file.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import paf_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    paf_req_t req = '0;
    logic busy;
    logic done;
    logic [3:0] wr_mask;
    paf_result_t result;
    paf_flags_t flags;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;

    paf_arith_unit uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .req_valid(req_valid), .req(req), .busy(busy), .done(done),
        .wr_mask(wr_mask), .result(result), .flags(flags));

    // Clock at 25 MHz.
    always #20 clk_sys = ~clk_sys;

    // Prints the counts and the verdict, then stops.
    task end_sim;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One comparison; an unknown never matches.
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Issues one request (c = exec, pointer error) and checks the outcome.
    task t_op(input paf_op_t op, input logic [31:0] a, input logic [31:0] b,
              input logic [1:0] c, input logic [3:0] m,
              input logic [63:0] e, input logic [5:0] f);
        paf_result_t old;
        int n;
        old = result;
        n = 0;
        req_valid = 1'b1;
        req = '{op, c[1], c[0], a, b};
        @(posedge clk_sys);
        #1;
        req_valid = 1'b0;
        while (c[1] && done !== 1'b1 && n < 40)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk("done", {31'h0, c[1]}, {31'h0, done});
        chk("mask", {28'h0, m}, {28'h0, wr_mask});
        chk("flags", {26'h0, f}, {26'h0, flags});
        for (int i = 0; i < 4; i++)
            chk("word", m[i] ? e[16*i +: 16] : old[16*i +: 16],
                {16'h0, result[16*i +: 16]});
        @(posedge clk_sys);
        #1;
    endtask

    // Cuts a hang short.
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            end_sim();
        end
    end

    // Main sequence; flags are {error, carry, equal, neg, over, under}.
    initial
    begin
        repeat (12) @(posedge clk_sys);
        #1;
        chk("rst", 32'h0, {flags, wr_mask, busy, done, result[15:0]});
        chk("rst_hi", 32'h0, result[63:32]);
        chk("rst_w1", 32'h0, {16'h0, result[31:16]});
        sys_rst = 1'b0;
        @(posedge clk_sys);
        #1;
        t_op(OP_ADD_SIGNED_SINGLE, 32'h7fff, 32'h1, 2'h2, 4'h1, 64'h8000,
             6'h06);
        t_op(OP_ADD_SIGNED_SINGLE, 32'h8000, 32'h8000, 2'h2, 4'h1, 64'h0,
             6'h19);
        t_op(OP_ADD_SIGNED_CARRY_SINGLE, 32'h1, 32'h1, 2'h2, 4'h1, 64'h3,
             6'h00);
        t_op(OP_ADD_SIGNED_DOUBLE, 32'hffffffff, 32'h1, 2'h2, 4'h3, 64'h0,
             6'h18);
        t_op(OP_ADD_SIGNED_CARRY_DOUBLE, 32'h1, 32'h2, 2'h2, 4'h3, 64'h4,
             6'h00);
        t_op(OP_ADD_DECIMAL_SINGLE, 32'h9999, 32'h1, 2'h2, 4'h1, 64'h0,
             6'h18);
        t_op(OP_ADD_DECIMAL_CARRY_SINGLE, 32'h1, 32'h2, 2'h2, 4'h1, 64'h4,
             6'h00);
        t_op(OP_ADD_DECIMAL_DOUBLE, 32'h99999999, 32'h1, 2'h2, 4'h3, 64'h0,
             6'h18);
        t_op(OP_ADD_DECIMAL_CARRY_DOUBLE, 32'h12345678, 32'h11111111, 2'h2,
             4'h3, 64'h23456790, 6'h00);
        t_op(OP_ADD_DECIMAL_SINGLE, 32'ha, 32'h1, 2'h2, 4'h0, 64'h0,
             6'h20);
        t_op(OP_SUB_BINARY_SINGLE, 32'h1, 32'h2, 2'h2, 4'h1, 64'hffff,
             6'h14);
        t_op(OP_ADD_SIGNED_SINGLE, 32'h1, 32'h1, 2'h3, 4'h0, 64'h0,
             6'h34);
        t_op(OP_SUB_BINARY_CARRY_SINGLE, 32'h5, 32'h2, 2'h2, 4'h1, 64'h2,
             6'h00);
        t_op(OP_SUB_BINARY_DOUBLE, 32'h0, 32'h1, 2'h2, 4'h3, 64'hffffffff,
             6'h14);
        t_op(OP_ADD_DECIMAL_DOUBLE, 32'ha0000000, 32'h0, 2'h2, 4'h0, 64'h0,
             6'h34);
        t_op(OP_ADD_SIGNED_SINGLE, 32'hffff, 32'hffff, 2'h0, 4'h0, 64'h0,
             6'h34);
        t_op(OP_DIVIDE_BINARY_DOUBLE, 32'h00100007, 32'h10, 2'h2, 4'hf,
             64'h7_00010000, 6'h10);
        t_op(OP_DIVIDE_BINARY_DOUBLE, 32'h80000000, 32'h1, 2'h2, 4'hf,
             64'h80000000, 6'h14);
        t_op(OP_DIVIDE_BINARY_DOUBLE, 32'h0, 32'h5, 2'h2, 4'hf, 64'h0,
             6'h18);
        t_op(OP_DIVIDE_BINARY_DOUBLE, 32'h9, 32'h0, 2'h2, 4'h0, 64'h0,
             6'h38);
        end_sim();
    end
endmodule // tb_top
